// File: hmd_map.vh
// Purpose: Shared constants for the hardware mode strap decoder.
// Assumes: Included by the decoder and its register slave.
// Notes: Offsets are byte addresses on a 32-bit APB bus.
`ifndef HMD_MAP_VH
`define HMD_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HMD_OFF_CTRL 12'h000
`define HMD_OFF_CH1 12'h004
`define HMD_OFF_CH2 12'h008
`define HMD_OFF_STAT 12'h00c
`define HMD_OFF_PINS 12'h010

// ****************************************************************
// Control register fields
// ****************************************************************
`define HMD_CTRL_SW_MODE 0
`define HMD_CTRL_JA_LO 1
`define HMD_CTRL_HIZ 3
`define HMD_CTRL_EDGE 4
`define HMD_CTRL_RST 32'h0000_0000

// ****************************************************************
// Channel register fields
// ****************************************************************
`define HMD_CH_PATT_LO 0
`define HMD_CH_GAIN 2
`define HMD_CH_LOOP_LO 3
`define HMD_CH_INBAND 5
`define HMD_CH_RST 32'h0000_0000

// ****************************************************************
// Decoded values
// ****************************************************************
`define HMD_FIFO_DEPTH_BROAD 8'd64
`define HMD_FIFO_DEPTH_NARROW 8'd128
`define HMD_GAIN_LOW_DB 5'd0
`define HMD_GAIN_HIGH_DB 5'd26

`endif

// File: hmd_apb_regs.v
// Purpose: APB slave holding the software control settings.
// Assumes: One clock, synchronous active low reset.
// Notes: Zero wait states; unmapped addresses read zero and report pslverr.
`timescale 1ns/1ps
`include "hmd_map.vh"

module hmd_apb_regs (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] stat_in,
  input wire [31:0] pins_in,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire [31:0] ctrl_out,
  output wire [31:0] ch1_out,
  output wire [31:0] ch2_out
);

  reg [31:0] ctrl_q;
  reg [31:0] ch1_q;
  reg [31:0] ch2_q;
  wire acc;
  wire mapped;

  // Merges write strobes into a stored word.
  function [31:0] hmd_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      hmd_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          hmd_merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Always ready, so every access completes in its first access cycle.
  assign acc = psel & penable;
  assign pready = 1'b1;
  assign mapped = (paddr == `HMD_OFF_CTRL) || (paddr == `HMD_OFF_CH1) ||
                  (paddr == `HMD_OFF_CH2) || (paddr == `HMD_OFF_STAT) ||
                  (paddr == `HMD_OFF_PINS);
  assign pslverr = acc & ~mapped;
  assign ctrl_out = ctrl_q;
  assign ch1_out = ch1_q;
  assign ch2_out = ch2_q;

  // Writes land only at the completing access edge.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q <= `HMD_CTRL_RST;
      ch1_q <= `HMD_CH_RST;
      ch2_q <= `HMD_CH_RST;
    end else if (acc && pwrite) begin
      if (paddr == `HMD_OFF_CTRL) begin
        ctrl_q <= hmd_merge(ctrl_q, pwdata, pstrb) & 32'h0000_001f;
      end
      if (paddr == `HMD_OFF_CH1) begin
        ch1_q <= hmd_merge(ch1_q, pwdata, pstrb) & 32'h0000_003f;
      end
      if (paddr == `HMD_OFF_CH2) begin
        ch2_q <= hmd_merge(ch2_q, pwdata, pstrb) & 32'h0000_003f;
      end
    end
  end

  // Read mux is combinational; data is valid during the access cycle.
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `HMD_OFF_CTRL: prdata = ctrl_q;
      `HMD_OFF_CH1: prdata = ch1_q;
      `HMD_OFF_CH2: prdata = ch2_q;
      `HMD_OFF_STAT: prdata = stat_in;
      `HMD_OFF_PINS: prdata = pins_in;
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule

// File: hmd_decode.v
// Purpose: Turns hardware mode strap pins or software settings into line settings.
// Assumes: Strap pins are asynchronous to clk_sys and pass two flip-flops.
// Notes: Line setting outputs are registered, so a pin change shows three edges later.
//
// Operation
// - A channel's pattern select gives normal for 00, all ones 01, PRBS 10, power down 11.
// - Jitter select 01 puts the attenuator in receive, broad bandwidth, 64-bit FIFO.
// - Jitter select 10 puts the attenuator in receive, narrow bandwidth, 128-bit FIFO.
// - Jitter select 11 puts the attenuator in transmit, narrow bandwidth, 128-bit FIFO.
// - The jitter setting is one global choice shared by both channels.
// - A receiver's monitor gain select gives 0 dB when low and 26 dB when high.
// - A channel's loopback select gives none 00, analog 01, digital 10, remote 11.
// - In-band loopback cannot be chosen from pins, only from software.
// - The driver high-impedance input low enables both drivers, high floats both.
// - The clock edge select 0 makes rising edges active, 1 makes falling active.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "hmd_map.vh"

module hmd_decode (
  input wire clk_sys,
  input wire rstn,
  input wire hw_mode_pin,
  input wire [1:0] tx_test_pattern_sel_ch1,
  input wire [1:0] tx_test_pattern_sel_ch2,
  input wire [1:0] jitter_atten_position_sel,
  input wire rx_monitor_gain_sel_ch1,
  input wire rx_monitor_gain_sel_ch2,
  input wire [1:0] loopback_mode_sel_ch1,
  input wire [1:0] loopback_mode_sel_ch2,
  input wire tx_driver_hiz_en,
  input wire rx_clock_edge_sel,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [3:0] tx_pattern_ch1,
  output reg [3:0] tx_pattern_ch2,
  output reg [4:0] rx_monitor_gain_db_ch1,
  output reg [4:0] rx_monitor_gain_db_ch2,
  output reg [4:0] loopback_ch1,
  output reg [4:0] loopback_ch2,
  output reg jitter_attenuator_en,
  output reg jitter_attenuator_in_tx,
  output reg jitter_attenuator_narrow_bw,
  output reg [7:0] jitter_attenuator_fifo_depth,
  output reg tx_driver_en_ch1,
  output reg tx_driver_en_ch2,
  output reg recovered_rx_clock_falling
);

  // ****************************************************************
  // Encodings
  // ****************************************************************
  // One-hot pattern codes: normal, all ones, PRBS, power down.
  localparam [3:0] PAT_NORMAL = 4'h1;
  localparam [3:0] PAT_ONES = 4'h2;
  localparam [3:0] PAT_PRBS = 4'h4;
  localparam [3:0] PAT_PDOWN = 4'h8;
  // One-hot loopback codes; in-band is reachable only from software.
  localparam [4:0] LB_NONE = 5'h01;
  localparam [4:0] LB_ANALOG = 5'h02;
  localparam [4:0] LB_DIGITAL = 5'h04;
  localparam [4:0] LB_REMOTE = 5'h08;
  localparam [4:0] LB_INBAND = 5'h10;
  localparam PIN_W = 15;

  wire [PIN_W-1:0] pins_raw;
  reg [PIN_W-1:0] pins_meta_q;
  reg [PIN_W-1:0] pins_q;
  wire [31:0] ctrl_w;
  wire [31:0] ch1_w;
  wire [31:0] ch2_w;
  reg hw_mode;
  reg [1:0] patt1;
  reg [1:0] patt2;
  reg gain1;
  reg gain2;
  reg [1:0] lp1;
  reg [1:0] lp2;
  reg inband1;
  reg inband2;
  reg [1:0] ja_sel;
  reg hiz;
  reg edge_sel;
  wire [31:0] stat_w;

  // Pattern decode, shared by both channels.
  function [3:0] hmd_patt;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: hmd_patt = PAT_NORMAL;
        2'b01: hmd_patt = PAT_ONES;
        2'b10: hmd_patt = PAT_PRBS;
        default: hmd_patt = PAT_PDOWN;
      endcase
    end
  endfunction

  // Loopback decode; the in-band request wins only when software allows it.
  function [4:0] hmd_loop;
    input [1:0] sel;
    input inband;
    begin
      if (inband) begin
        hmd_loop = LB_INBAND;
      end else begin
        case (sel)
          2'b00: hmd_loop = LB_NONE;
          2'b01: hmd_loop = LB_ANALOG;
          2'b10: hmd_loop = LB_DIGITAL;
          default: hmd_loop = LB_REMOTE;
        endcase
      end
    end
  endfunction

  // Gain decode from a one-bit select.
  function [4:0] hmd_gain;
    input sel;
    begin
      hmd_gain = sel ? `HMD_GAIN_HIGH_DB : `HMD_GAIN_LOW_DB;
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  assign pins_raw = {hw_mode_pin, rx_clock_edge_sel, tx_driver_hiz_en,
                     jitter_atten_position_sel, loopback_mode_sel_ch2,
                     loopback_mode_sel_ch1, rx_monitor_gain_sel_ch2,
                     rx_monitor_gain_sel_ch1, tx_test_pattern_sel_ch2,
                     tx_test_pattern_sel_ch1};

  // Straps are quasi-static, but a pin can move at any time, so two stages guard metastability.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pins_meta_q <= {PIN_W{1'b0}};
      pins_q <= {PIN_W{1'b0}};
    end else begin
      pins_meta_q <= pins_raw;
      pins_q <= pins_meta_q;
    end
  end

  // ****************************************************************
  // Register slave
  // ****************************************************************
  assign stat_w = {8'h00, jitter_attenuator_fifo_depth, 3'h0, recovered_rx_clock_falling,
                   tx_driver_en_ch2, tx_driver_en_ch1, jitter_attenuator_narrow_bw,
                   jitter_attenuator_in_tx, jitter_attenuator_en, hw_mode,
                   tx_pattern_ch2[3], tx_pattern_ch1[3], 4'h0};

  hmd_apb_regs u_regs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .stat_in(stat_w),
    .pins_in({{(32-PIN_W){1'b0}}, pins_q}),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl_out(ctrl_w),
    .ch1_out(ch1_w),
    .ch2_out(ch2_w)
  );

  // ****************************************************************
  // Source selection
  // ****************************************************************
  // Hardware mode needs the pin high and software not overriding it.
  always @* begin
    hw_mode = pins_q[14] & ~ctrl_w[`HMD_CTRL_SW_MODE];
    if (hw_mode) begin
      patt1 = pins_q[1:0];
      patt2 = pins_q[3:2];
      gain1 = pins_q[4];
      gain2 = pins_q[5];
      lp1 = pins_q[7:6];
      lp2 = pins_q[9:8];
      inband1 = 1'b0;
      inband2 = 1'b0;
      ja_sel = pins_q[11:10];
      hiz = pins_q[12];
      edge_sel = pins_q[13];
    end else begin
      patt1 = ch1_w[`HMD_CH_PATT_LO +: 2];
      patt2 = ch2_w[`HMD_CH_PATT_LO +: 2];
      gain1 = ch1_w[`HMD_CH_GAIN];
      gain2 = ch2_w[`HMD_CH_GAIN];
      lp1 = ch1_w[`HMD_CH_LOOP_LO +: 2];
      lp2 = ch2_w[`HMD_CH_LOOP_LO +: 2];
      inband1 = ch1_w[`HMD_CH_INBAND];
      inband2 = ch2_w[`HMD_CH_INBAND];
      ja_sel = ctrl_w[`HMD_CTRL_JA_LO +: 2];
      hiz = ctrl_w[`HMD_CTRL_HIZ];
      edge_sel = ctrl_w[`HMD_CTRL_EDGE];
    end
  end

  // ****************************************************************
  // Registered settings
  // ****************************************************************
  // Outputs are flopped so the datapaths never see a decode glitch.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      tx_pattern_ch1 <= PAT_NORMAL;
      tx_pattern_ch2 <= PAT_NORMAL;
      rx_monitor_gain_db_ch1 <= `HMD_GAIN_LOW_DB;
      rx_monitor_gain_db_ch2 <= `HMD_GAIN_LOW_DB;
      loopback_ch1 <= LB_NONE;
      loopback_ch2 <= LB_NONE;
      tx_driver_en_ch1 <= 1'b0;
      tx_driver_en_ch2 <= 1'b0;
      recovered_rx_clock_falling <= 1'b0;
    end else begin
      tx_pattern_ch1 <= hmd_patt(patt1);
      tx_pattern_ch2 <= hmd_patt(patt2);
      rx_monitor_gain_db_ch1 <= hmd_gain(gain1);
      rx_monitor_gain_db_ch2 <= hmd_gain(gain2);
      loopback_ch1 <= hmd_loop(lp1, inband1);
      loopback_ch2 <= hmd_loop(lp2, inband2);
      tx_driver_en_ch1 <= ~hiz;
      tx_driver_en_ch2 <= ~hiz;
      recovered_rx_clock_falling <= edge_sel;
    end
  end

  // One global jitter setting drives both channels alike.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      jitter_attenuator_en <= 1'b0;
      jitter_attenuator_in_tx <= 1'b0;
      jitter_attenuator_narrow_bw <= 1'b0;
      jitter_attenuator_fifo_depth <= 8'd0;
    end else begin
      case (ja_sel)
        2'b00: begin
          jitter_attenuator_en <= 1'b0;
          jitter_attenuator_in_tx <= 1'b0;
          jitter_attenuator_narrow_bw <= 1'b0;
          jitter_attenuator_fifo_depth <= 8'd0;
        end
        2'b01: begin
          jitter_attenuator_en <= 1'b1;
          jitter_attenuator_in_tx <= 1'b0;
          jitter_attenuator_narrow_bw <= 1'b0;
          jitter_attenuator_fifo_depth <= `HMD_FIFO_DEPTH_BROAD;
        end
        2'b10: begin
          jitter_attenuator_en <= 1'b1;
          jitter_attenuator_in_tx <= 1'b0;
          jitter_attenuator_narrow_bw <= 1'b1;
          jitter_attenuator_fifo_depth <= `HMD_FIFO_DEPTH_NARROW;
        end
        default: begin
          jitter_attenuator_en <= 1'b1;
          jitter_attenuator_in_tx <= 1'b1;
          jitter_attenuator_narrow_bw <= 1'b1;
          jitter_attenuator_fifo_depth <= `HMD_FIFO_DEPTH_NARROW;
        end
      endcase
    end
  end

endmodule

// File: hmd_decode_asserts.sv
// Purpose: Assertions on the strap decoder outputs in hardware mode.
// Assumes: A pin change reaches the outputs three edges later.
// Notes: Software mode is tracked from APB writes to the control word.
`timescale 1ns/1ps
`include "hmd_map.vh"
module hmd_decode_asserts (
  input wire clk_sys,
  input wire rstn,
  input wire hw_mode_pin,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [1:0] tx_test_pattern_sel_ch1,
  input wire [1:0] tx_test_pattern_sel_ch2,
  input wire [1:0] jitter_atten_position_sel,
  input wire rx_monitor_gain_sel_ch1,
  input wire rx_monitor_gain_sel_ch2,
  input wire [1:0] loopback_mode_sel_ch1,
  input wire [1:0] loopback_mode_sel_ch2,
  input wire tx_driver_hiz_en,
  input wire rx_clock_edge_sel,
  input wire [3:0] tx_pattern_ch1,
  input wire [3:0] tx_pattern_ch2,
  input wire [4:0] rx_monitor_gain_db_ch1,
  input wire [4:0] rx_monitor_gain_db_ch2,
  input wire [4:0] loopback_ch1,
  input wire [4:0] loopback_ch2,
  input wire jitter_attenuator_en,
  input wire jitter_attenuator_in_tx,
  input wire jitter_attenuator_narrow_bw,
  input wire [7:0] jitter_attenuator_fifo_depth,
  input wire tx_driver_en_ch1,
  input wire tx_driver_en_ch2,
  input wire recovered_rx_clock_falling
);
  reg sw_q;
  reg [2:0] cnt_q;
  // Six quiet cycles in hardware mode leave margin for the two synchroniser stages.
  wire hw_ok = (cnt_q >= 3'h6);
  wire [1:0] ja = jitter_atten_position_sel;
  wire [10:0] jv = {jitter_attenuator_en, jitter_attenuator_in_tx,
                    jitter_attenuator_narrow_bw, jitter_attenuator_fifo_depth};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Tracks the software override bit and how long hardware mode has held.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sw_q <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      if (psel && penable && pwrite && paddr == `HMD_OFF_CTRL) begin
        sw_q <= pwdata[0];
      end
      if (!hw_mode_pin || sw_q) begin
        cnt_q <= 3'h0;
      end else if (cnt_q != 3'h7) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Pin decode checks
  // ****************************************************************
  property p_patt; hw_ok |-> tx_pattern_ch1 == (4'h1 << $past(tx_test_pattern_sel_ch1, 3))
    && tx_pattern_ch2 == (4'h1 << $past(tx_test_pattern_sel_ch2, 3)); endproperty
  a_patt: assert property (p_patt) else $error("pattern wrong");
  property p_ja_off; hw_ok && $past(ja, 3) == 2'h0 |-> jv == 11'h000; endproperty
  a_ja_off: assert property (p_ja_off) else $error("jitter off wrong");
  property p_ja_rxb; hw_ok && $past(ja, 3) == 2'h1 |-> jv == {3'h4, 8'h40}; endproperty
  a_ja_rxb: assert property (p_ja_rxb) else $error("jitter 01 wrong");
  property p_ja_rxn; hw_ok && $past(ja, 3) == 2'h2 |-> jv == {3'h5, 8'h80}; endproperty
  a_ja_rxn: assert property (p_ja_rxn) else $error("jitter 10 wrong");
  property p_ja_tx; hw_ok && $past(ja, 3) == 2'h3 |-> jv == {3'h7, 8'h80}; endproperty
  a_ja_tx: assert property (p_ja_tx) else $error("jitter 11 wrong");
  property p_gain; hw_ok |-> rx_monitor_gain_db_ch1 == ($past(rx_monitor_gain_sel_ch1, 3) ?
    5'h1a : 5'h00) && rx_monitor_gain_db_ch2 == ($past(rx_monitor_gain_sel_ch2, 3) ? 5'h1a : 5'h00);
  endproperty
  a_gain: assert property (p_gain) else $error("gain wrong");
  property p_loop; hw_ok |-> loopback_ch1 == (5'h01 << $past(loopback_mode_sel_ch1, 3))
    && loopback_ch2 == (5'h01 << $past(loopback_mode_sel_ch2, 3)); endproperty
  a_loop: assert property (p_loop) else $error("loopback wrong");
  property p_hiz; hw_ok |-> tx_driver_en_ch1 == !$past(tx_driver_hiz_en, 3)
    && tx_driver_en_ch2 == tx_driver_en_ch1; endproperty
  a_hiz: assert property (p_hiz) else $error("driver enable wrong");
  property p_edge; hw_ok |-> recovered_rx_clock_falling == $past(rx_clock_edge_sel, 3); endproperty
  a_edge: assert property (p_edge) else $error("clock edge wrong");
  cover property (hw_ok && jitter_attenuator_in_tx);
  cover property (!hw_ok && loopback_ch1[4]);
  cover property (hw_ok && !tx_driver_en_ch1);
endmodule

bind hmd_decode hmd_decode_asserts u_hmd_decode_asserts (.*);

// File: hmd_strap_drv.sv
// Purpose: Board strap model driving the hardware mode pins.
// Assumes: Straps are resistors, so every pin always has a level.
// Notes: Bit order matches the synchronised pin read-back word.
`timescale 1ns/1ps
module hmd_strap_drv (
  input wire [14:0] strap_cfg,
  output wire hw_mode_pin,
  output wire [1:0] tx_test_pattern_sel_ch1,
  output wire [1:0] tx_test_pattern_sel_ch2,
  output wire [1:0] jitter_atten_position_sel,
  output wire rx_monitor_gain_sel_ch1,
  output wire rx_monitor_gain_sel_ch2,
  output wire [1:0] loopback_mode_sel_ch1,
  output wire [1:0] loopback_mode_sel_ch2,
  output wire tx_driver_hiz_en,
  output wire rx_clock_edge_sel
);
  // Straps never float, so no released state is modelled.
  assign {hw_mode_pin, rx_clock_edge_sel, tx_driver_hiz_en, jitter_atten_position_sel,
          loopback_mode_sel_ch2, loopback_mode_sel_ch1, rx_monitor_gain_sel_ch2,
          rx_monitor_gain_sel_ch1, tx_test_pattern_sel_ch2, tx_test_pattern_sel_ch1} = strap_cfg;
endmodule

// File: hmd_decode_tb.sv
// Purpose: Self-checking bench for the strap decoder.
// Assumes: Zero wait state APB slave; pins settle in three edges.
// Notes: Row table covers every select code on both channels.
`timescale 1ns/1ps
`include "hmd_map.vh"
module hmd_decode_tb;
  typedef struct packed {
    logic [3:0] patt;
    logic [4:0] loopb;
    logic [4:0] gain;
    logic [10:0] ja;
    logic drv;
    logic fall;
  } hmd_row_t;
  hmd_row_t rows [0:3];
  reg clk_sys, rstn, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [3:0] pstrb;
  reg [14:0] strap_cfg;
  reg err;
  integer failures, compares, i, n;
  wire hw_mode_pin, rx_monitor_gain_sel_ch1, rx_monitor_gain_sel_ch2, tx_driver_hiz_en;
  wire rx_clock_edge_sel, pready, pslverr, jitter_attenuator_en, jitter_attenuator_in_tx;
  wire jitter_attenuator_narrow_bw, tx_driver_en_ch1, tx_driver_en_ch2, recovered_rx_clock_falling;
  wire [1:0] tx_test_pattern_sel_ch1, tx_test_pattern_sel_ch2, jitter_atten_position_sel;
  wire [1:0] loopback_mode_sel_ch1, loopback_mode_sel_ch2;
  wire [31:0] prdata;
  wire [3:0] tx_pattern_ch1, tx_pattern_ch2;
  wire [4:0] rx_monitor_gain_db_ch1, rx_monitor_gain_db_ch2, loopback_ch1, loopback_ch2;
  wire [7:0] jitter_attenuator_fifo_depth;
  wire [10:0] jv = {jitter_attenuator_en, jitter_attenuator_in_tx,
                    jitter_attenuator_narrow_bw, jitter_attenuator_fifo_depth};

  hmd_strap_drv u_hmd_strap_drv (.*);
  hmd_decode u_hmd_decode (.*);

  // Free-running 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Counts every compare and reports a mismatch at once.
  task chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the completing edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n = n + 1;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures = failures + 1;
      print_verdict;
    end
  endtask

  // Holds a strap setting long enough to pass the synchronisers.
  task settle(input logic [14:0] cfg);
    @(posedge clk_sys);
    strap_cfg <= cfg;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // Guards against a hang anywhere in the run.
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures = failures + 1;
    print_verdict;
  end

  // Main sequence: reset values first, then rows, then the mixed, software and reset cases.
  initial begin
    failures = 0;
    compares = 0;
    {rstn, psel, penable, pwrite, paddr, pwdata} = 0;
    pstrb = 4'hf;
    strap_cfg = 15'h4000;
    rows[0] = {4'h1, 5'h01, 5'h00, 11'h000, 1'b1, 1'b0};
    rows[1] = {4'h2, 5'h02, 5'h1a, 3'h4, 8'h40, 1'b0, 1'b0};
    rows[2] = {4'h4, 5'h04, 5'h00, 3'h5, 8'h80, 1'b1, 1'b1};
    rows[3] = {4'h8, 5'h08, 5'h1a, 3'h7, 8'h80, 1'b0, 1'b1};
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rst_patt", tx_pattern_ch1, 4'h1);
    chk("rst_drv", {tx_driver_en_ch1, tx_driver_en_ch2}, 2'h0);
    @(posedge clk_sys);
    rstn <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      settle({1'b1, i[1], i[0], i[1:0], i[1:0], i[1:0], i[0], i[0], i[1:0], i[1:0]});
      chk("patt1", tx_pattern_ch1, rows[i].patt);
      chk("patt2", tx_pattern_ch2, rows[i].patt);
      chk("gain1", rx_monitor_gain_db_ch1, rows[i].gain);
      chk("gain2", rx_monitor_gain_db_ch2, rows[i].gain);
      chk("loop1", loopback_ch1, rows[i].loopb);
      chk("loop2", loopback_ch2, rows[i].loopb);
      chk("jitter", jv, rows[i].ja);
      chk("drv", {tx_driver_en_ch1, tx_driver_en_ch2}, {2{rows[i].drv}});
      chk("edge", recovered_rx_clock_falling, rows[i].fall);
      apb(1'b0, `HMD_OFF_PINS, 32'h0);
      chk("pins", rd, {17'h0, strap_cfg});
      $display("row %0d done", i);
    end
    // Channel patterns and loopbacks differ, so a shared decode of those would show here.
    settle(15'h5a79);
    chk("mix_patt", {tx_pattern_ch1, tx_pattern_ch2}, 8'h24);
    chk("mix_gain", {rx_monitor_gain_db_ch1, rx_monitor_gain_db_ch2}, 10'h35a);
    chk("mix_loop", {loopback_ch1, loopback_ch2}, 10'h044);
    chk("mix_ja", jv, {3'h5, 8'h80});
    chk("mix_drv", {tx_driver_en_ch1, tx_driver_en_ch2}, 2'h0);
    $display("mixed channel test done");
    // Software override with in-band loopback requested.
    apb(1'b1, `HMD_OFF_CTRL, 32'h17);
    apb(1'b1, `HMD_OFF_CH1, 32'h2f);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("sw_patt", {tx_pattern_ch1, tx_pattern_ch2}, 8'h81);
    chk("sw_gain", rx_monitor_gain_db_ch1, 5'h1a);
    chk("sw_loop", loopback_ch1, 5'h10);
    chk("sw_ja", jv, {3'h7, 8'h80});
    chk("sw_drv", {tx_driver_en_ch1, tx_driver_en_ch2, recovered_rx_clock_falling}, 3'h7);
    apb(1'b0, `HMD_OFF_CTRL, 32'h0);
    chk("ctrl_rd", {err, rd}, 33'h0_0000_0017);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", {err, rd}, 33'h1_0000_0000);
    apb(1'b1, `HMD_OFF_CTRL, 32'h0);
    settle(15'h5a79);
    chk("hw_loop", loopback_ch1, 5'h02);
    $display("software test done");
    // Second reset in mid-run clears outputs and registers.
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rst2_loop", loopback_ch1, 5'h01);
    @(posedge clk_sys);
    rstn <= 1'b1;
    apb(1'b0, `HMD_OFF_CH1, 32'h0);
    chk("rst2_ch1", rd, 32'h0);
    $display("reset test done");
    print_verdict;
  end
endmodule
